// ---- rtl/pci_target_wide_local_datapath.sv ----
// Purpose: Target data path between a PCI bus and a 64-bit local back-end
// Assumes: All bus and local inputs synchronous to i_core_clk
// Notes:   Configuration space, parity and master mode live elsewhere
`timescale 1ns/1ps
// Operation
// (RULE_01) Held ready keeps trdyn, shows last QWORD
// (RULE_02) Master sends next enables and QWORD after transfer
// (RULE_03) Master ends wide burst dropping framen, req64n
// (RULE_04) Completed transfer asserts both DWORD strobes
// (RULE_05) Master releases bus after final transfer
// (RULE_06) Turnaround deasserts devseln, ack64n and trdyn
// (RULE_07) Burst end shown only by clearing window match
// (RULE_08) Idle cycle drops strobes and releases controls
// (RULE_09) Narrow bus uses two phases per QWORD
// (RULE_10) Narrow burst leaves upper local half meaningless
// (RULE_11) QWORD-stepped back-end, strobes pick the DWORD
// (RULE_12) Start address bit two picks first half
// (RULE_13) Unaligned start must still be DWORD aligned
// (RULE_14) After address phase drive captured local address
// (RULE_15) Address match drives window match outputs
// (RULE_16) Slow select asserts devseln after window match
// (RULE_17) Back-end signals ready one cycle before data
// (RULE_18) Aligned read fetch asserts low strobe after ready
// (RULE_19) Two ready cycles start trdyn and first DWORD
// (RULE_20) Alternate strobes; back-end holds without high strobe
// (RULE_21) Wide request raises the wide transfer flag
// (RULE_22) Write trdyn follows back-end ready by one cycle
module pci_target_wide_local_datapath #(
	parameter logic [pci_wide_pkg::WIN_N-1:0][31:0] WIN_BASE = pci_wide_pkg::WIN_BASE_DEF
) (
	// Clock and reset
	input  wire logic      i_core_clk,
	input  wire logic      i_rst_n,
	// Configuration
	input  wire logic      i_pci64_mode,
	input  wire logic      i_slow_select,
	// Link
	pci_wide_if.target_end link
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		pci_wide_pkg::tgt_state_type      state;
		logic                             frame_prev;
		logic [31:0]                      laddr;
		logic [3:0]                       cmd;
		logic                             wide;
		logic                             hi_ptr;
		logic                             latched;
		logic                             fetch;
		logic [31:0]                      hi_latch;
		logic                             rdy_prev;
		logic [pci_wide_pkg::WIN_N-1:0]   match;
		logic                             devsel_n;
		logic                             trdy_n;
		logic                             ack64_n;
		logic                             ctl_oe;
		logic [63:0]                      ad;
		logic                             ad_oe;
		logic                             lo_stb_n;
		logic                             hi_stb_n;
		logic [63:0]                      wdata;
	} tgt_regs_type;

	localparam tgt_regs_type TGT_RST = '{
		state:      pci_wide_pkg::TGT_IDLE,
		frame_prev: 1'b1,
		devsel_n:   1'b1,
		trdy_n:     1'b1,
		ack64_n:    1'b1,
		lo_stb_n:   1'b1,
		hi_stb_n:   1'b1,
		default:    '0
	};

	tgt_regs_type                   q_r;
	tgt_regs_type                   q_nxt;
	logic [pci_wide_pkg::WIN_N-1:0] hit;
	logic                           cmd_ok;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign cmd_ok = (q_r.cmd == pci_wide_pkg::CMD_MEM_READ) ||
		(q_r.cmd == pci_wide_pkg::CMD_MEM_WRITE) ||
		(q_r.cmd == pci_wide_pkg::CMD_READ_MULT) ||
		(q_r.cmd == pci_wide_pkg::CMD_READ_LINE);

	for (genvar i = 0; i < pci_wide_pkg::WIN_N; i++) begin : g_win
		assign hit[i] = cmd_ok && ((q_r.laddr & pci_wide_pkg::WIN_MASK) == WIN_BASE[i]);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic is_rd;
		logic xfer;
		logic last;
		logic load;
		logic step;
		logic show_hi;
		is_rd   = q_r.cmd != pci_wide_pkg::CMD_MEM_WRITE;
		xfer    = (q_r.state == pci_wide_pkg::TGT_DATA) && !link.irdyn && !q_r.trdy_n;
		last    = xfer && link.framen;
		load    = is_rd && q_r.trdy_n && q_r.rdy_prev && !link.backend_ready_n;
		step    = is_rd && xfer && !last;
		show_hi = step ? !q_r.hi_ptr : q_r.hi_ptr;
		q_nxt            = q_r;
		q_nxt.frame_prev = link.framen;
		q_nxt.rdy_prev   = !link.backend_ready_n;
		q_nxt.lo_stb_n   = 1'b1;
		q_nxt.hi_stb_n   = 1'b1;
		unique case (q_r.state)
			pci_wide_pkg::TGT_IDLE: begin
				// Only a fresh frame start counts, never the middle of a foreign burst
				if (!link.framen && q_r.frame_prev) begin
					q_nxt.state   = pci_wide_pkg::TGT_DECODE;
					q_nxt.laddr   = link.ad[31:0]; // [RULE_14]
					q_nxt.cmd     = link.cben[3:0];
					q_nxt.wide    = !link.req64n && i_pci64_mode; // [RULE_21]
					q_nxt.hi_ptr  = link.ad[pci_wide_pkg::DWORD_SEL_BIT]; // [RULE_12]
					q_nxt.latched = 1'b0;
				end
			end
			pci_wide_pkg::TGT_DECODE: begin
				q_nxt.match = hit; // [RULE_15]
				q_nxt.state = (|hit) ? pci_wide_pkg::TGT_MATCH : pci_wide_pkg::TGT_IDLE;
				if (!(|hit)) begin
					q_nxt.wide = 1'b0;
				end else if (!i_slow_select) begin
					q_nxt.state    = pci_wide_pkg::TGT_DATA;
					q_nxt.devsel_n = 1'b0;
					q_nxt.ack64_n  = !q_r.wide;
					q_nxt.ctl_oe   = 1'b1;
					q_nxt.fetch    = 1'b1;
					q_nxt.ad_oe    = is_rd;
				end
			end
			pci_wide_pkg::TGT_MATCH: begin
				q_nxt.state    = pci_wide_pkg::TGT_DATA;
				q_nxt.devsel_n = 1'b0; // [RULE_16]
				q_nxt.ack64_n  = !q_r.wide;
				q_nxt.ctl_oe   = 1'b1;
				q_nxt.fetch    = 1'b1;
				q_nxt.ad_oe    = is_rd;
			end
			pci_wide_pkg::TGT_DATA: begin
				if (is_rd) begin
					q_nxt.trdy_n = !(q_r.rdy_prev && !link.backend_ready_n); // [RULE_19]
					if (q_r.fetch && !link.backend_ready_n) begin
						q_nxt.fetch = 1'b0;
						// First fetch names the half; a wide read takes whole QWORDs, so
						// the back-end moves on at once and the next QWORD is ready in time
						q_nxt.lo_stb_n = q_r.hi_ptr && !q_r.wide; // [RULE_18]
						q_nxt.hi_stb_n = !q_r.hi_ptr && !q_r.wide;
					end
					if (q_r.wide && (load || step)) begin
						q_nxt.ad       = link.local_read_data;
						q_nxt.lo_stb_n = 1'b0;
						q_nxt.hi_stb_n = 1'b0;
					end else if (load || step) begin
						q_nxt.hi_ptr = show_hi; // [RULE_09]
						if (show_hi) begin
							q_nxt.ad       = {32'h0000_0000,
								q_r.latched ? q_r.hi_latch : link.local_read_data[63:32]};
							q_nxt.latched  = 1'b0;
							q_nxt.lo_stb_n = link.irdyn || link.backend_ready_n; // [RULE_11]
						end else begin
							// Upper half kept because the back-end moves on next cycle
							q_nxt.ad       = {32'h0000_0000, link.local_read_data[31:0]}; // [RULE_19]
							q_nxt.hi_latch = link.local_read_data[63:32];
							q_nxt.latched  = 1'b1;
							q_nxt.hi_stb_n = link.irdyn; // [RULE_20]
						end
					end
				end else begin
					q_nxt.trdy_n = link.backend_ready_n; // [RULE_22] [RULE_01]
					if (xfer && q_r.wide) begin
						q_nxt.wdata    = link.ad; // [RULE_01]
						q_nxt.lo_stb_n = 1'b0; // [RULE_04]
						q_nxt.hi_stb_n = 1'b0; // [RULE_04]
					end else if (xfer && i_pci64_mode) begin
						q_nxt.wdata    = {32'h0000_0000, link.ad[31:0]}; // [RULE_10]
						q_nxt.lo_stb_n = 1'b0;
					end else if (xfer) begin
						q_nxt.hi_ptr = !q_r.hi_ptr; // [RULE_09]
						if (q_r.hi_ptr) begin
							q_nxt.wdata[63:32] = link.ad[31:0];
							q_nxt.hi_stb_n     = 1'b0; // [RULE_11]
						end else begin
							q_nxt.wdata[31:0] = link.ad[31:0];
							q_nxt.lo_stb_n    = 1'b0; // [RULE_11]
						end
					end
				end
				if (last) begin
					q_nxt.state    = pci_wide_pkg::TGT_TURN;
					q_nxt.devsel_n = 1'b1; // [RULE_06]
					q_nxt.trdy_n   = 1'b1; // [RULE_06]
					q_nxt.ack64_n  = 1'b1; // [RULE_06]
					q_nxt.ad_oe    = 1'b0;
				end
			end
			pci_wide_pkg::TGT_TURN: begin
				// Back-end learns of the end only here
				q_nxt.state  = pci_wide_pkg::TGT_IDLE;
				q_nxt.match  = '0; // [RULE_07]
				q_nxt.wide   = 1'b0;
				q_nxt.ctl_oe = 1'b0; // [RULE_08]
			end
			default: begin
				q_nxt = TGT_RST;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_r <= TGT_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.ad_t                = q_r.ad;
	assign link.ad_t_oe             = q_r.ad_oe;
	assign link.devsel_drv          = q_r.devsel_n;
	assign link.trdy_drv            = q_r.trdy_n;
	assign link.ack64_drv           = q_r.ack64_n;
	assign link.ctl_oe              = q_r.ctl_oe;
	assign link.local_addr_out      = q_r.laddr;
	assign link.local_cmd           = q_r.cmd;
	assign link.window_match        = q_r.match;
	assign link.wide_transfer_flag  = q_r.wide;
	assign link.low_dword_strobe_n  = q_r.lo_stb_n;
	assign link.high_dword_strobe_n = q_r.hi_stb_n;
	assign link.local_write_data    = q_r.wdata;
endmodule : pci_target_wide_local_datapath

// ---- rtl/pci_wide_pkg.sv ----
// Purpose: Shared constants and types for the wide local target data path
// Assumes: One 100 MHz clock, active-low asynchronous reset
// Notes:   Bus pins resolve with pull-ups inside the link interface
package pci_wide_pkg;
	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int          WIN_N          = 2;
	localparam int          COUNT_W        = 4;
	localparam int          IDX_W          = 3;
	localparam int          IDX_LSB        = 3;
	localparam int          DWORD_SEL_BIT  = 2;
	localparam int          BACKEND_DEPTH  = 8;
	// ------------------------------------------------------------
	// Commands and decode
	// ------------------------------------------------------------
	localparam logic [3:0]  CMD_MEM_READ   = 4'h6;
	localparam logic [3:0]  CMD_MEM_WRITE  = 4'h7;
	localparam logic [3:0]  CMD_READ_MULT  = 4'hC;
	localparam logic [3:0]  CMD_READ_LINE  = 4'hE;
	localparam logic [31:0] WIN_MASK       = 32'hFFFF_F000;
	localparam logic [WIN_N-1:0][31:0] WIN_BASE_DEF = {32'h0000_2000, 32'h0000_1000};
	// ------------------------------------------------------------
	// Reset and idle values
	// ------------------------------------------------------------
	localparam logic [7:0]  BE_ALL         = 8'h00;
	localparam logic [7:0]  CBE_IDLE       = 8'hFF;
	localparam logic [63:0] AD_IDLE        = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [31:0] SEQ_RST        = 32'h0000_0000;
	// ------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TGT_IDLE   = 3'b000,
		TGT_DECODE = 3'b001,
		TGT_MATCH  = 3'b010,
		TGT_DATA   = 3'b011,
		TGT_TURN   = 3'b100
	} tgt_state_type;
	typedef enum logic [1:0] {
		MST_IDLE = 2'b00,
		MST_ADDR = 2'b01,
		MST_DATA = 2'b10,
		MST_REL  = 2'b11
	} mst_state_type;
endpackage : pci_wide_pkg

// ---- rtl/pci_wide_if.sv ----
// Purpose: Link between the target data path and the master/back-end end
// Assumes: Shared pins are open when not enabled and float high
// Notes:   Pull-up resolution stands in for tri-state wires
`timescale 1ns/1ps
interface pci_wide_if;
	// ------------------------------------------------------------
	// Master drives
	// ------------------------------------------------------------
	logic                                  frame_drv;
	logic                                  req64_drv;
	logic                                  frame_oe;
	logic                                  irdy_drv;
	logic                                  irdy_oe;
	logic [7:0]                            cben_drv;
	logic [63:0]                           ad_m;
	logic                                  ad_m_oe;
	// ------------------------------------------------------------
	// Target drives
	// ------------------------------------------------------------
	logic [63:0]                           ad_t;
	logic                                  ad_t_oe;
	logic                                  devsel_drv;
	logic                                  trdy_drv;
	logic                                  ack64_drv;
	logic                                  ctl_oe;
	// ------------------------------------------------------------
	// Resolved bus
	// ------------------------------------------------------------
	logic                                  framen;
	logic                                  req64n;
	logic                                  irdyn;
	logic [7:0]                            cben;
	logic [63:0]                           ad;
	logic                                  devseln;
	logic                                  trdyn;
	logic                                  ack64n;
	assign framen  = frame_oe ? frame_drv : 1'b1;
	assign req64n  = frame_oe ? req64_drv : 1'b1;
	assign cben    = frame_oe ? cben_drv : pci_wide_pkg::CBE_IDLE;
	assign irdyn   = irdy_oe ? irdy_drv : 1'b1;
	assign ad      = ad_t_oe ? ad_t : (ad_m_oe ? ad_m : pci_wide_pkg::AD_IDLE);
	assign devseln = ctl_oe ? devsel_drv : 1'b1;
	assign trdyn   = ctl_oe ? trdy_drv : 1'b1;
	assign ack64n  = ctl_oe ? ack64_drv : 1'b1;
	// ------------------------------------------------------------
	// Local side
	// ------------------------------------------------------------
	logic [31:0]                           local_addr_out;
	logic [3:0]                            local_cmd;
	logic [pci_wide_pkg::WIN_N-1:0]        window_match;
	logic                                  wide_transfer_flag;
	logic                                  low_dword_strobe_n;
	logic                                  high_dword_strobe_n;
	logic [63:0]                           local_write_data;
	logic [63:0]                           local_read_data;
	logic                                  backend_ready_n;

	modport target_end (
		input  framen, req64n, irdyn, cben, ad, local_read_data, backend_ready_n,
		output ad_t, ad_t_oe, devsel_drv, trdy_drv, ack64_drv, ctl_oe,
		output local_addr_out, local_cmd, window_match, wide_transfer_flag,
		output low_dword_strobe_n, high_dword_strobe_n, local_write_data
	);
	modport far_end (
		input  devseln, trdyn, ack64n, ad,
		input  local_addr_out, local_cmd, window_match, wide_transfer_flag,
		input  low_dword_strobe_n, high_dword_strobe_n, local_write_data,
		output frame_drv, req64_drv, frame_oe, irdy_drv, irdy_oe, cben_drv,
		output ad_m, ad_m_oe, local_read_data, backend_ready_n
	);
endinterface : pci_wide_if

// ---- rtl/pci_far_end.sv ----
// Purpose: Bus master and QWORD back-end facing the target data path
// Assumes: Target answers every burst inside a decoded window
// Notes:   No master abort timer; an unclaimed burst waits forever
`timescale 1ns/1ps
module pci_far_end #(
	parameter int DEPTH = pci_wide_pkg::BACKEND_DEPTH
) (
	// Clock and reset
	input  wire logic                               i_core_clk,
	input  wire logic                               i_rst_n,
	// Burst request
	input  wire logic                               i_start,
	input  wire logic                               i_write,
	input  wire logic                               i_wide,
	input  wire logic [31:0]                        i_addr,
	input  wire logic [pci_wide_pkg::COUNT_W-1:0]   i_count,
	// Status
	output logic                                    o_busy,
	output logic                                    o_done,
	output logic [63:0]                             o_rdata,
	// Link
	pci_wide_if.far_end                             link
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		pci_wide_pkg::mst_state_type          state;
		logic [pci_wide_pkg::COUNT_W-1:0]     remaining;
		logic                                 wide;
		logic                                 write;
		logic                                 frame_n;
		logic                                 req64_n;
		logic                                 frame_oe;
		logic                                 irdy_n;
		logic                                 irdy_oe;
		logic                                 ad_oe;
		logic [63:0]                          ad;
		logic [7:0]                           cben;
		logic [31:0]                          seq;
		logic                                 busy;
		logic                                 done;
		logic [63:0]                          rdata_last;
		logic                                 sel;
		logic                                 ready_n;
		logic [pci_wide_pkg::IDX_W-1:0]       bidx;
		logic [63:0]                          rdata;
		logic [DEPTH-1:0][63:0]               mem;
	} far_regs_type;

	localparam far_regs_type FAR_RST = '{
		state:   pci_wide_pkg::MST_IDLE,
		frame_n: 1'b1,
		req64_n: 1'b1,
		irdy_n:  1'b1,
		cben:    pci_wide_pkg::CBE_IDLE,
		seq:     pci_wide_pkg::SEQ_RST,
		ready_n: 1'b1,
		default: '0
	};

	far_regs_type q_r;
	far_regs_type q_nxt;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic xfer;
		logic is_wr;
		xfer  = (q_r.state == pci_wide_pkg::MST_DATA) && !q_r.irdy_n && !link.trdyn;
		is_wr = link.local_cmd == pci_wide_pkg::CMD_MEM_WRITE;
		q_nxt = q_r;
		unique case (q_r.state)
			pci_wide_pkg::MST_IDLE: begin
				q_nxt.done = 1'b0;
				if (i_start && (i_count != '0)) begin
					q_nxt.state     = pci_wide_pkg::MST_ADDR;
					q_nxt.remaining = i_count;
					q_nxt.wide      = i_wide;
					q_nxt.write     = i_write;
					q_nxt.frame_n   = 1'b0;
					q_nxt.req64_n   = !i_wide;
					q_nxt.frame_oe  = 1'b1;
					q_nxt.ad_oe     = 1'b1;
					// Low address bits forced to a DWORD boundary
					q_nxt.ad        = {32'h0000_0000, i_addr[31:2], 2'b00}; // [RULE_13]
					q_nxt.cben      = {4'hF, i_write ? pci_wide_pkg::CMD_MEM_WRITE
						: pci_wide_pkg::CMD_MEM_READ};
					q_nxt.busy      = 1'b1;
				end
			end
			pci_wide_pkg::MST_ADDR: begin
				q_nxt.state   = pci_wide_pkg::MST_DATA;
				q_nxt.irdy_n  = 1'b0;
				q_nxt.irdy_oe = 1'b1;
				q_nxt.cben    = pci_wide_pkg::BE_ALL;
				q_nxt.ad_oe   = q_r.write;
				q_nxt.ad      = q_r.wide ? {q_r.seq + 32'h0000_0001, q_r.seq}
					: {32'h0000_0000, q_r.seq};
				q_nxt.frame_n = q_r.remaining == 4'h1; // [RULE_03]
				q_nxt.req64_n = !q_r.wide || (q_r.remaining == 4'h1); // [RULE_03]
			end
			pci_wide_pkg::MST_DATA: begin
				if (xfer && !q_r.write) begin
					q_nxt.rdata_last = link.ad;
				end
				if (xfer && (q_r.remaining == 4'h1)) begin
					q_nxt.state    = pci_wide_pkg::MST_REL;
					q_nxt.frame_oe = 1'b0; // [RULE_05]
					q_nxt.ad_oe    = 1'b0; // [RULE_05]
					q_nxt.irdy_n   = 1'b1; // [RULE_05]
				end else if (xfer) begin
					q_nxt.remaining = q_r.remaining - 4'h1;
					q_nxt.seq       = q_r.seq + (q_r.wide ? 32'h0000_0002 : 32'h0000_0001);
					q_nxt.cben      = pci_wide_pkg::BE_ALL; // [RULE_02]
					q_nxt.ad        = q_r.wide ? {q_nxt.seq + 32'h0000_0001, q_nxt.seq}
						: {32'h0000_0000, q_nxt.seq}; // [RULE_02]
					q_nxt.frame_n   = q_r.remaining == 4'h2; // [RULE_03]
					q_nxt.req64_n   = !q_r.wide || (q_r.remaining == 4'h2);
				end
			end
			pci_wide_pkg::MST_REL: begin
				q_nxt.state   = pci_wide_pkg::MST_IDLE;
				q_nxt.irdy_oe = 1'b0;
				q_nxt.busy    = 1'b0;
				q_nxt.done    = 1'b1;
			end
		endcase
		// Back-end: always ready while selected, so data follows one cycle on
		q_nxt.ready_n = ~|link.window_match; // [RULE_17]
		if (!q_r.sel && (|link.window_match)) begin
			q_nxt.sel  = 1'b1;
			q_nxt.bidx = link.local_addr_out[pci_wide_pkg::IDX_LSB +: pci_wide_pkg::IDX_W];
		end else if (~|link.window_match) begin
			q_nxt.sel = 1'b0;
		end else if (is_wr) begin
			if (!link.low_dword_strobe_n) begin
				q_nxt.mem[q_r.bidx][31:0] = link.local_write_data[31:0];
			end
			// Upper half meaningless on a narrow burst, so it is not stored
			if (!link.high_dword_strobe_n) begin
				q_nxt.mem[q_r.bidx][63:32] = link.local_write_data[63:32]; // [RULE_10]
				q_nxt.bidx = q_r.bidx + 3'h1; // [RULE_04] [RULE_11]
			end
		end else if (!link.high_dword_strobe_n) begin
			q_nxt.bidx = q_r.bidx + 3'h1; // [RULE_20]
		end
		q_nxt.rdata = q_nxt.mem[q_nxt.bidx]; // [RULE_18]
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_r <= FAR_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.frame_drv       = q_r.frame_n;
	assign link.req64_drv       = q_r.req64_n;
	assign link.frame_oe        = q_r.frame_oe;
	assign link.irdy_drv        = q_r.irdy_n;
	assign link.irdy_oe         = q_r.irdy_oe;
	assign link.cben_drv        = q_r.cben;
	assign link.ad_m            = q_r.ad;
	assign link.ad_m_oe         = q_r.ad_oe;
	assign link.local_read_data = q_r.rdata;
	assign link.backend_ready_n = q_r.ready_n;
	assign o_busy               = q_r.busy;
	assign o_done               = q_r.done;
	assign o_rdata              = q_r.rdata_last;
endmodule : pci_far_end

// ---- dv/pci_target_wide_local_datapath_checker.sv ----
// Purpose: Link assertions for the wide target data path
// Assumes: One clock, reset active low
// Notes:   Sees resolved pins only
`timescale 1ns/1ps
module pci_target_wide_local_datapath_checker (
	// Clock, reset, mode
	input wire logic i_core_clk, i_rst_n, i_pci64_mode, i_slow_select,
	// Bus pins
	input wire logic framen, irdyn, trdyn, devseln, ack64n, ctl_oe,
	// Local side
	input wire logic [3:0] local_cmd,
	input wire logic [pci_wide_pkg::WIN_N-1:0] window_match,
	input wire logic wide_transfer_flag, low_dword_strobe_n, high_dword_strobe_n,
	input wire logic backend_ready_n
);
	// ----------------
	// Helpers
	// ----------------
	logic xfer, is_wr, rdy_lo, both_lo, none_lo, wide_wr;
	assign xfer = !irdyn && !trdyn;
	assign is_wr = local_cmd == pci_wide_pkg::CMD_MEM_WRITE;
	assign rdy_lo = !backend_ready_n;
	assign both_lo = !low_dword_strobe_n && !high_dword_strobe_n;
	assign none_lo = low_dword_strobe_n && high_dword_strobe_n;
	assign wide_wr = i_pci64_mode && wide_transfer_flag && is_wr;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Final phase: framen already high at the transfer
	sequence last_xfer;
		xfer && framen;
	endsequence
	chk_turn_release: assert property (last_xfer |=> devseln && trdyn && ack64n)
		else $error("select held in turnaround");
	chk_idle_match: assert property (last_xfer |=> |window_match ##1 !(|window_match))
		else $error("window match not cleared at idle");
	chk_idle_release: assert property (last_xfer |=> ##1 none_lo && !ctl_oe)
		else $error("strobes or drive kept in idle");
	chk_write_trdy: assert property (!trdyn && is_wr |-> $past(rdy_lo))
		else $error("write trdyn without prior ready");
	chk_held_trdy: assert property (!trdyn && !framen && rdy_lo && is_wr |=> !trdyn)
		else $error("trdyn dropped with ready held");
	chk_read_start: assert property (!trdyn && !is_wr |-> $past(rdy_lo) && $past(rdy_lo, 2))
		else $error("read trdyn before two ready cycles");
	chk_slow_sel: assert property (i_slow_select && $rose(|window_match) |-> devseln ##1 !devseln)
		else $error("slow select timing wrong");
	chk_wide_pair: assert property (wide_wr && xfer |=> both_lo)
		else $error("wide write strobes not paired");
	chk_narrow_one: assert property (!i_pci64_mode |-> !both_lo)
		else $error("both strobes on narrow bus");
endmodule : pci_target_wide_local_datapath_checker

// ---- dv/pci_target_wide_local_datapath_tb_top.sv ----
// Purpose: Bursts through both ends of the link
// Assumes: 100 MHz clock, reset held 2 cycles
// Notes:   Link counters feed the comparisons
`timescale 1ns/1ps
module pci_target_wide_local_datapath_tb_top;
	logic i_core_clk = 1'h0, i_rst_n = 1'h0, i_pci64_mode = 1'h1, i_slow_select = 1'h1;
	logic i_start = 1'h0, i_write = 1'h0, i_wide = 1'h0, o_done, o_busy, s_wide;
	logic [63:0] o_rdata;
	logic [31:0] i_addr = 32'h0000_0000, s_addr;
	logic [pci_wide_pkg::COUNT_W-1:0] i_count = 4'h0;
	logic [pci_wide_pkg::WIN_N-1:0] s_match;
	int n_xf = 0, n_lo = 0, n_hi = 0, mismatches = 0, checks = 0;
	pci_wide_if link ();
	always #5 i_core_clk = ~i_core_clk;
	pci_target_wide_local_datapath pci_target_wide_local_datapath_i (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_pci64_mode(i_pci64_mode), .i_slow_select(i_slow_select), .link(link));
	pci_far_end pci_far_end_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(i_start),
		.i_write(i_write), .i_wide(i_wide), .i_addr(i_addr), .i_count(i_count),
		.o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata), .link(link));
	pci_target_wide_local_datapath_checker link_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_pci64_mode(i_pci64_mode), .i_slow_select(i_slow_select), .framen(link.framen),
		.irdyn(link.irdyn), .trdyn(link.trdyn), .devseln(link.devseln), .ack64n(link.ack64n),
		.ctl_oe(link.ctl_oe), .local_cmd(link.local_cmd), .window_match(link.window_match),
		.wide_transfer_flag(link.wide_transfer_flag), .backend_ready_n(link.backend_ready_n),
		.low_dword_strobe_n(link.low_dword_strobe_n), .high_dword_strobe_n(link.high_dword_strobe_n));
	// ----------------
	// Link monitor; counters cleared by each start
	// ----------------
	always @(posedge i_core_clk) begin
		n_xf <= i_start ? 0 : n_xf + int'(!link.irdyn && !link.trdyn);
		n_lo <= i_start ? 0 : n_lo + int'(!link.low_dword_strobe_n);
		n_hi <= i_start ? 0 : n_hi + int'(!link.high_dword_strobe_n);
		if (|link.window_match) begin
			{s_addr, s_match, s_wide} <= {link.local_addr_out, link.window_match, link.wide_transfer_flag};
		end
	end
	task automatic cmp(input string what, input logic [31:0] exp, got);
		checks++;
		mismatches += int'(exp !== got);
		if (exp !== got) $display("unexpected %s: expected %0h seen %0h", what, exp, got);
	endtask : cmp
	task automatic results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	// Done is a one-cycle pulse, so it is watched on falling edges
	task automatic run(input logic m, s, w, wd, input logic [31:0] a, input int c,
		input logic [31:0] rd);
		int lo = (!m && w) ? (a[2] ? c / 2 : (c + 1) / 2) : c;
		@(posedge i_core_clk);
		{i_pci64_mode, i_slow_select, i_write, i_wide} <= {m, s, w, wd};
		{i_addr, i_count, i_start} <= {a, c[3:0], 1'h1};
		@(posedge i_core_clk);
		i_start <= 1'h0;
		repeat (300) if (o_done !== 1'h1) @(negedge i_core_clk);
		cmp("done", 1, o_done);
		cmp("busy", 0, o_busy);
		repeat (4) @(negedge i_core_clk);
		if (!w) cmp("read data", rd, o_rdata[31:0]);
		cmp("transfers", c, n_xf);
		cmp("local address", a, s_addr);
		cmp("window match", a[13] ? 2 : 1, s_match);
		if (m) cmp("wide flag", wd, s_wide);
		if (w) cmp("low strobes", lo, n_lo);
		if (w) cmp("high strobes", m ? (wd ? c : 0) : c - lo, n_hi);
	endtask : run
	initial begin
		repeat (2) @(posedge i_core_clk);
		i_rst_n <= 1'h1;
		run(1'h1, 1'h1, 1'h1, 1'h1, 32'h0000_1000, 3, 32'h0000_0000);
		run(1'h1, 1'h0, 1'h1, 1'h1, 32'h0000_2008, 1, 32'h0000_0000);
		run(1'h1, 1'h1, 1'h0, 1'h1, 32'h0000_1000, 2, 32'h0000_0004);
		run(1'h0, 1'h1, 1'h1, 1'h0, 32'h0000_1000, 3, 32'h0000_0000);
		run(1'h0, 1'h0, 1'h1, 1'h0, 32'h0000_2004, 4, 32'h0000_0000);
		run(1'h0, 1'h1, 1'h0, 1'h0, 32'h0000_1000, 4, 32'h0000_000A);
		run(1'h0, 1'h1, 1'h0, 1'h0, 32'h0000_1004, 3, 32'h0000_000A);
		run(1'h1, 1'h1, 1'h1, 1'h0, 32'h0000_1000, 2, 32'h0000_0000);
		results();
	end
	// Eight bursts need well under 5000 cycles
	initial begin
		#50000;
		mismatches++;
		results();
	end
endmodule : pci_target_wide_local_datapath_tb_top
